// file: core/tcc_top.sv
// Purpose: capture/compare control of a 16-bit timer/event counter
// Assumes: i_clk 250 MHz; pins asynchronous; software obeys its rules
// Notes:   count clock is a one-cycle enable from a divider or pin edge
// Operation
// - mode bit selects compare or capture
// - trigger select: second pin or reverse
// - both edges plus reverse detects nothing
// - second pin edge under reverse: interrupt, no capture
// - second pin edge from prescaler bits 6,5
// - counter readable without disturbing count
// - event count match after M+1 events
// - second register match always raises interrupt
// - value 07H measures pulse width
// - reverse phase capture raises no interrupt
// - reset clears control to zero
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`include "tcc_map.svh"
module tcc_top
  import tcc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // timer input pins
  input wire logic i_first_timer_input_pin,
  input wire logic i_second_timer_input_pin,
  // interrupt
  output logic o_irq
);

  // ==================================================================
  // declarations
  logic [1:0] rst_q;
  logic rst_n;
  logic [1:0] pins_s;
  tcc_pins_type pins;
  tcc_pins_type prev_clk_q;
  tcc_pins_type samp_q;
  tcc_ctrl_type ctrl_q;
  logic [7:0] prm_q;
  logic [7:0] tmc_q;
  logic [15:0] cnt_q;
  logic [15:0] cr0_q;
  logic [15:0] cr1_q;
  logic [1:0] stat_q;
  logic [1:0] mask_q;
  logic [15:0] rdata_q;
  logic irq_q;
  logic [7:0] div_q;
  logic [7:0] div_lim;
  tcc_edge_type es0;
  tcc_edge_type es1;
  tcc_ps_type ps;
  tcc_opmode_type opm;
  logic run;
  logic ext_tick;
  logic tick;
  logic ce;
  logic r0, f0, r1, f1;
  logic e0, e1, rev0;
  logic cap0, cap1, ext_irq0;
  logic match0, match1;
  logic [1:0] ev;
  logic wr_ctrl, wr_prm, wr_tmc, wr_cr0, wr_cr1, wr_stat, wr_mask;

  // edge filter by valid edge selection
  function automatic logic edge_hit(tcc_edge_type sel, logic rise,
                                    logic fall);
    case (sel)
      TCC_EDGE_FALL: edge_hit = fall;
      TCC_EDGE_RISE: edge_hit = rise;
      TCC_EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  // ==================================================================
  // reset release through two flip-flops
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      rst_q <= 2'h0;
    else
      rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  // ==================================================================
  // pin synchronisers
  tcc_sync #(
    .W(2)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_d({i_second_timer_input_pin, i_first_timer_input_pin}),
    .o_q(pins_s)
  );
  assign pins = tcc_pins_type'(pins_s);

  // field views
  assign es0 = tcc_edge_type'(prm_q[`TCC_ES0_HI:`TCC_ES0_LO]);
  assign es1 = tcc_edge_type'(prm_q[`TCC_ES1_HI:`TCC_ES1_LO]);
  assign ps = tcc_ps_type'(prm_q[`TCC_PS_HI:`TCC_PS_LO]);
  assign opm = tcc_opmode_type'(tmc_q[`TCC_OPM_HI:`TCC_OPM_LO]);
  assign run = (opm != TCC_OPM_STOP);

  // ==================================================================
  // count clock: divider enable, or external events on the first pin
  assign div_lim = (ps == TCC_PS_DIVA) ? `TCC_DIV_A : `TCC_DIV_B;

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_q <= 8'h00;
    else if (div_q >= div_lim - 8'h01)
      div_q <= 8'h00;
    else
      div_q <= div_q + 8'h01;
  end

  // edge history at full rate, for event counting
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      prev_clk_q <= '0;
    else
      prev_clk_q <= pins;
  end

  // external events are first pin valid edges
  assign ext_tick = edge_hit(es0,
    pins.first_timer_input_pin & ~prev_clk_q.first_timer_input_pin,
    ~pins.first_timer_input_pin & prev_clk_q.first_timer_input_pin);

  always_comb
  begin
    case (ps)
      TCC_PS_DIV1: tick = 1'b1;
      TCC_PS_EXT: tick = ext_tick;
      default: tick = (div_q == div_lim - 8'h01);
    endcase
  end
  assign ce = tick & run;

  // ==================================================================
  // pins sampled once per count clock
  // sampling continues while stopped so a start sees no stale edge
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      samp_q <= '0;
    else if (tick)
      samp_q <= pins;
  end

  assign r0 = pins.first_timer_input_pin & ~samp_q.first_timer_input_pin;
  assign f0 = ~pins.first_timer_input_pin & samp_q.first_timer_input_pin;
  assign r1 = pins.second_timer_input_pin
            & ~samp_q.second_timer_input_pin;
  assign f1 = ~pins.second_timer_input_pin
            & samp_q.second_timer_input_pin;
  assign e0 = edge_hit(es0, r0, f0);
  assign e1 = edge_hit(es1, r1, f1);
  // reverse phase of both edges never fires
  assign rev0 = (es0 != TCC_EDGE_BOTH) & edge_hit(es0, f0, r0);

  // ==================================================================
  // capture and compare events
  // trigger source of the first register
  assign cap0 = ce & ctrl_q.first_reg_mode_bit
              & (ctrl_q.capture_trigger_select_bit ? rev0 : e1);
  // second pin edge only interrupts under reverse phase
  assign ext_irq0 = ce & ctrl_q.capture_trigger_select_bit & e1;
  // second register captures on first pin valid edge
  assign cap1 = ce & ctrl_q.second_reg_mode_bit & e0;
  // compare only while in compare mode
  assign match0 = ce & ~ctrl_q.first_reg_mode_bit & (cnt_q == cr0_q);
  // second register match needs no mode other than compare
  assign match1 = ce & ~ctrl_q.second_reg_mode_bit & (cnt_q == cr1_q);
  // reverse phase capture adds no interrupt
  assign ev[`TCC_IRQ0] = match0 | ext_irq0
    | (cap0 & ~ctrl_q.capture_trigger_select_bit);
  assign ev[`TCC_IRQ1] = match1 | cap1;

  // ==================================================================
  // counter; compare uses the value before the tick's increment
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= `TCC_CNT_RST;
    else if (!run)
      cnt_q <= `TCC_CNT_RST;
    else if (ce)
    begin
      // match on value M clears, after M+1 events
      if ((opm == TCC_OPM_MATCH_CLR && cnt_q == cr0_q)
          || (opm == TCC_OPM_EDGE_CLR && e0))
        cnt_q <= `TCC_CNT_RST;
      else
        cnt_q <= cnt_q + 16'h0001;
    end
  end

  // ==================================================================
  // register write decode
  assign wr_ctrl = i_wr & (i_addr == `TCC_OFS_CTRL);
  assign wr_prm = i_wr & (i_addr == `TCC_OFS_PRM);
  assign wr_tmc = i_wr & (i_addr == `TCC_OFS_TMC);
  assign wr_cr0 = i_wr & (i_addr == `TCC_OFS_CR0);
  assign wr_cr1 = i_wr & (i_addr == `TCC_OFS_CR1);
  assign wr_stat = i_wr & (i_addr == `TCC_OFS_STAT);
  assign wr_mask = i_wr & (i_addr == `TCC_OFS_MASK);

  // control clears to zero on reset
  // writes while running are taken; software must avoid them
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_q <= `TCC_CTRL_RST;
    else if (wr_ctrl)
      ctrl_q <= tcc_ctrl_type'(i_wdata[2:0]);
  end

  // mode registers
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prm_q <= `TCC_PRM_RST;
      tmc_q <= `TCC_TMC_RST;
      mask_q <= `TCC_MASK_RST;
    end
    else
    begin
      if (wr_prm)
        prm_q <= i_wdata[7:0];
      if (wr_tmc)
        tmc_q <= i_wdata[7:0];
      if (wr_mask)
        mask_q <= i_wdata[1:0];
    end
  end

  // capture wins over a software write in the same cycle
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cr0_q <= `TCC_CNT_RST;
      cr1_q <= `TCC_CNT_RST;
    end
    else
    begin
      if (cap0)
        cr0_q <= cnt_q;
      else if (wr_cr0)
        cr0_q <= i_wdata;
      if (cap1)
        cr1_q <= cnt_q;
      else if (wr_cr1)
        cr1_q <= i_wdata;
    end
  end

  // ==================================================================
  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      stat_q <= `TCC_STAT_RST;
    else
      stat_q <= (stat_q & ~(wr_stat ? i_wdata[1:0] : 2'h0)) | ev;
  end

  // mask bit set blocks its status bit from the output
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_q <= 1'b0;
    else
      irq_q <= |(stat_q & ~mask_q);
  end
  assign o_irq = irq_q;

  // ==================================================================
  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= `TCC_RDATA_IDLE;
    else if (!i_rd)
      rdata_q <= `TCC_RDATA_IDLE;
    else
    begin
      case (i_addr)
        `TCC_OFS_CTRL: rdata_q <= {13'h0, ctrl_q};
        `TCC_OFS_PRM: rdata_q <= {8'h00, prm_q};
        `TCC_OFS_TMC: rdata_q <= {8'h00, tmc_q};
        // live counter, read has no side effect
        `TCC_OFS_CNT: rdata_q <= cnt_q;
        `TCC_OFS_CR0: rdata_q <= cr0_q;
        `TCC_OFS_CR1: rdata_q <= cr1_q;
        `TCC_OFS_STAT: rdata_q <= {14'h0, stat_q};
        `TCC_OFS_MASK: rdata_q <= {14'h0, mask_q};
        default: rdata_q <= `TCC_RDATA_IDLE;
      endcase
    end
  end
  assign o_rdata = rdata_q;

  // ==================================================================
  // checks
  rd_idle_a:
    assert property (@(posedge i_clk) disable iff (!rst_n)
      !$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not idle");

  cnt_read_a:
    assert property (@(posedge i_clk) disable iff (!rst_n)
      i_rd && i_addr == `TCC_OFS_CNT && !i_wr |=> o_rdata == $past(cnt_q))
    else $error("counter read wrong");

  cap0_value_a:
    assert property (@(posedge i_clk) disable iff (!rst_n)
      cap0 |=> cr0_q == $past(cnt_q))
    else $error("first capture value wrong");

  cap1_value_a:
    assert property (@(posedge i_clk) disable iff (!rst_n)
      ce && ctrl_q.second_reg_mode_bit && e0 |=> cr1_q == $past(cnt_q))
    else $error("second capture value wrong");

  both_edge_a:
    assert property (@(posedge i_clk) disable iff (!rst_n)
      ctrl_q.capture_trigger_select_bit && es0 == TCC_EDGE_BOTH |-> !cap0)
    else $error("capture despite both edges");

  rev_noirq_a:
    assert property (@(posedge i_clk) disable iff (!rst_n)
      cap0 && ctrl_q.capture_trigger_select_bit && !e1
      && !stat_q[`TCC_IRQ0] |=> !stat_q[`TCC_IRQ0])
    else $error("reverse capture raised interrupt");

  ext_irq_a:
    assert property (@(posedge i_clk) disable iff (!rst_n)
      ce && ctrl_q.capture_trigger_select_bit && e1 && !rev0
      |=> stat_q[`TCC_IRQ0] && $stable(cr0_q))
    else $error("second pin edge handling wrong");

  event_match_a:
    assert property (@(posedge i_clk) disable iff (!rst_n)
      ce && opm == TCC_OPM_MATCH_CLR && !ctrl_q.first_reg_mode_bit
      && cnt_q == cr0_q |=> cnt_q == 16'h0000 && stat_q[`TCC_IRQ0])
    else $error("event match wrong");

  cmp1_irq_a:
    assert property (@(posedge i_clk) disable iff (!rst_n)
      match1 |=> stat_q[`TCC_IRQ1] ##1 o_irq || mask_q[`TCC_IRQ1]
      || $past(wr_stat))
    else $error("second match interrupt lost");

  reset_ctrl_a:
    assert property (@(posedge i_clk)
      $rose(rst_n) |-> ctrl_q == tcc_ctrl_type'(`TCC_CTRL_RST))
    else $error("control not cleared by reset");

  compare_mode_a:
    assert property (@(posedge i_clk) disable iff (!rst_n)
      !ctrl_q.first_reg_mode_bit && !wr_cr0 |=> $stable(cr0_q))
    else $error("compare register changed");

endmodule

// file: shared/tcc_map.svh
// Purpose: register offsets, field positions, reset values and divider
//          counts of the timer capture/compare block
// Assumes: 16-bit register port, 4-bit word address
// Notes:   definitions only
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH

// ====================================================================
// register offsets (word index on the register port)
`define TCC_OFS_CTRL 4'h0
`define TCC_OFS_PRM 4'h1
`define TCC_OFS_TMC 4'h2
`define TCC_OFS_CNT 4'h3
`define TCC_OFS_CR0 4'h4
`define TCC_OFS_CR1 4'h5
`define TCC_OFS_STAT 4'h6
`define TCC_OFS_MASK 4'h7

// ====================================================================
// field positions
`define TCC_PS_HI 1
`define TCC_PS_LO 0
`define TCC_OPM_HI 3
`define TCC_OPM_LO 2
`define TCC_ES0_HI 4
`define TCC_ES0_LO 3
`define TCC_ES1_HI 6
`define TCC_ES1_LO 5
`define TCC_IRQ0 0
`define TCC_IRQ1 1

// ====================================================================
// reset values
`define TCC_CTRL_RST 3'h0
`define TCC_PRM_RST 8'h00
`define TCC_TMC_RST 8'h00
`define TCC_CNT_RST 16'h0000
`define TCC_STAT_RST 2'h0
`define TCC_MASK_RST 2'h3
`define TCC_RDATA_IDLE 16'h0000

// ====================================================================
// internal count clock divider lengths, in i_clk cycles
`define TCC_DIV_A 8'h04
`define TCC_DIV_B 8'h10
`endif

// file: shared/tcc_pkg.sv
// Purpose: types shared by the timer capture/compare block
// Assumes: encodings match the prescaler and mode fields
// Notes:   constants live in tcc_map.svh
package tcc_pkg;

  // ==================================================================
  // valid edge selection of a timer input pin
  typedef enum logic [1:0] {
    TCC_EDGE_FALL = 2'h0,
    TCC_EDGE_RISE = 2'h1,
    TCC_EDGE_NONE = 2'h2,
    TCC_EDGE_BOTH = 2'h3
  } tcc_edge_type;

  // timer operating mode
  typedef enum logic [1:0] {
    TCC_OPM_STOP = 2'h0,
    TCC_OPM_FREE = 2'h1,
    TCC_OPM_EDGE_CLR = 2'h2,
    TCC_OPM_MATCH_CLR = 2'h3
  } tcc_opmode_type;

  // count clock source
  typedef enum logic [1:0] {
    TCC_PS_DIV1 = 2'h0,
    TCC_PS_DIVA = 2'h1,
    TCC_PS_DIVB = 2'h2,
    TCC_PS_EXT = 2'h3
  } tcc_ps_type;

  // capture/compare control register fields
  typedef struct packed {
    logic second_reg_mode_bit;
    logic capture_trigger_select_bit;
    logic first_reg_mode_bit;
  } tcc_ctrl_type;

  // synchronised timer input pins
  typedef struct packed {
    logic second_timer_input_pin;
    logic first_timer_input_pin;
  } tcc_pins_type;

endpackage

// file: core/tcc_sync.sv
// Purpose: two flip-flop synchroniser for asynchronous pin inputs
// Assumes: inputs are levels from outside the i_clk domain
// Notes:   the first stage feeds only the second stage
`timescale 1ns/10ps
module tcc_sync #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  // ==================================================================
  // one two-stage chain per bit
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end
        else
        begin
          meta_q <= i_d[g];
          sync_q <= meta_q;
        end
      end
      assign o_q[g] = sync_q;
    end
  endgenerate

endmodule

// file: verif/tcc_pins_model.sv
// Purpose: outside signal sources on the two timer input pins
// Assumes: count clock is i_clk or first pin edges, so i_clk sets timing
// Notes:   levels change right after a rising edge, never mid-cycle
`timescale 1ns/10ps
module tcc_pins_model (
  // clock
  input wire logic i_clk,
  // pin levels
  output logic o_first,
  output logic o_second
);
  // ==================================================================
  // pins idle low until a scenario moves them
  initial
  begin
    o_first = 1'b0;
    o_second = 1'b0;
  end

  // levels held long enough
  // a shorter level could slip between two sampling ticks
  task automatic drive(input bit sel, input bit lvl, input int n);
    int k;
    k = (n < 3) ? 3 : n;
    @(posedge i_clk);
    if (sel)
      o_second <= lvl;
    else
      o_first <= lvl;
    repeat (k - 1) @(posedge i_clk);
  endtask
endmodule

// file: verif/tcc_top_test.sv
// Purpose: self-checking bench of the timer capture/compare block
// Assumes: register map and port timing of the hand-over
// Notes:   expected register contents kept in a small model array
`timescale 1ns/10ps
`include "tcc_map.svh"
module tcc_top_test
  import tcc_pkg::*;
;
  logic i_clk;
  logic i_resetn;
  logic [3:0] i_addr;
  logic [15:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [15:0] o_rdata;
  logic pin_a;
  logic pin_b;
  logic o_irq;
  int fail_count;
  int total_checks;
  int seed;
  int m;
  logic [15:0] h;
  logic [15:0] v;
  logic [15:0] w;
  logic [15:0] model_q [8];

  // ==================================================================
  // design and pin sources
  tcc_top DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_first_timer_input_pin(pin_a), .i_second_timer_input_pin(pin_b),
    .o_irq(o_irq));
  tcc_pins_model pins (.i_clk(i_clk), .o_first(pin_a), .o_second(pin_b));

  // ==================================================================
  // clock, 4 ns period
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // watchdog, well beyond the few hundred cycles the tests take
  initial
  begin
    #40000;
    fail_count++;
    results();
  end

  // ==================================================================
  // comparison and register port tasks
  task automatic chk(input string n, input logic [15:0] e,
    input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // model keeps only what a write may change, in the register widths
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    case (a)
      `TCC_OFS_CTRL: model_q[0] = d & 16'h0007;
      `TCC_OFS_PRM: model_q[1] = d & 16'h00ff;
      `TCC_OFS_CR0: model_q[4] = d;
      `TCC_OFS_CR1: model_q[5] = d;
      `TCC_OFS_MASK: model_q[7] = d & 16'h0003;
      default: ;
    endcase
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  task automatic rc(input string n, input logic [3:0] a,
    input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk(n, e, d);
  endtask

  // stop, clear status, then set control and prescaler
  // second register parked at the top so a run from zero cannot match it
  task automatic setup(input logic [15:0] c, input logic [15:0] p);
    wr(`TCC_OFS_TMC, 16'h0000);
    wr(`TCC_OFS_STAT, 16'h0003);
    wr(`TCC_OFS_CTRL, c);
    wr(`TCC_OFS_PRM, p);
    wr(`TCC_OFS_CR1, 16'hffff);
  endtask

  task automatic pulse(input bit sel);
    pins.drive(sel, 1'b1, 4);
    pins.drive(sel, 1'b0, 4);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==================================================================
  // main sequence
  initial
  begin
    seed = 90;
    fail_count = 0;
    total_checks = 0;
    i_resetn = 1'b0;
    i_addr = 4'h0;
    i_wdata = 16'h0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    foreach (model_q[i])
      model_q[i] = 16'h0000;
    model_q[7] = 16'h0003;
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clk);

    // reset values, access kinds, unmapped place
    rc("ctrl_rst", `TCC_OFS_CTRL, 16'h0000);
    rc("mask_rst", `TCC_OFS_MASK, 16'h0003);
    rc("stat_rst", `TCC_OFS_STAT, 16'h0000);
    wr(`TCC_OFS_CTRL, 16'($random(seed)));
    wr(`TCC_OFS_PRM, 16'($random(seed)));
    rc("ctrl_rw", `TCC_OFS_CTRL, model_q[0]);
    rc("prm_rw", `TCC_OFS_PRM, model_q[1]);
    wr(4'h9, 16'hffff);
    rc("unmapped", 4'h9, 16'h0000);
    wr(`TCC_OFS_TMC, 16'h0000);
    wr(`TCC_OFS_CNT, 16'h1234);
    rc("cnt_ro", `TCC_OFS_CNT, 16'h0000);
    $display("test registers done");

    // free run on i_clk, two reads two cycles apart
    setup(16'h0000, 16'h0000);
    wr(`TCC_OFS_TMC, 16'h0004);
    rd(`TCC_OFS_CNT, v);
    rd(`TCC_OFS_CNT, w);
    chk("cnt_step", 16'h0002, w - v);
    $display("test counter done");

    // capture on second pin rise only, compare mode keeps value
    setup(16'h0001, 16'h0020);
    wr(`TCC_OFS_TMC, 16'h0004);
    rd(`TCC_OFS_CNT, v);
    pins.drive(1'b1, 1'b1, 8);
    rd(`TCC_OFS_CR0, w);
    chk("cap_win", 16'h0001, {15'h0, (w - v) < 16'd9 && w != v});
    pins.drive(1'b1, 1'b0, 6);
    rc("cap_fall", `TCC_OFS_CR0, w);
    rc("cap_irq", `TCC_OFS_STAT, 16'h0001);
    setup(16'h0000, 16'h0020);
    wr(`TCC_OFS_CR0, 16'h5a5a);
    wr(`TCC_OFS_TMC, 16'h0004);
    pulse(1'b1);
    rc("cmp_keep", `TCC_OFS_CR0, 16'h5a5a);
    $display("test capture done");

    // reverse phase: second pin raises status only
    setup(16'h0003, 16'h0030);
    wr(`TCC_OFS_CR0, 16'h0abc);
    wr(`TCC_OFS_TMC, 16'h0004);
    pulse(1'b1);
    rc("rev_nocap", `TCC_OFS_CR0, 16'h0abc);
    rc("rev_irq", `TCC_OFS_STAT, 16'h0001);
    // both edges on first pin with reverse phase finds no edge
    setup(16'h0003, 16'h0058);
    wr(`TCC_OFS_TMC, 16'h0004);
    pulse(1'b0);
    rc("both_none", `TCC_OFS_CR0, 16'h0abc);
    $display("test reverse done");

    // pulse width of a random high level, value 07h
    h = 16'd4 + 16'($random(seed) & 15);
    setup(16'h0007, 16'h0040);
    wr(`TCC_OFS_TMC, 16'h000a);
    pins.drive(1'b0, 1'b1, int'(h));
    pins.drive(1'b0, 1'b0, 6);
    rd(`TCC_OFS_CR0, v);
    rd(`TCC_OFS_CR1, w);
    chk("width", h, w - v);
    rc("width_irq", `TCC_OFS_STAT, 16'h0002);
    $display("test width done");

    // interrupt level against mask and clear
    repeat (2) @(posedge i_clk);
    #1;
    chk("irq_masked", 16'h0000, {15'h0, o_irq});
    wr(`TCC_OFS_MASK, 16'h0001);
    repeat (2) @(posedge i_clk);
    #1;
    chk("irq_on", 16'h0001, {15'h0, o_irq});
    wr(`TCC_OFS_STAT, 16'h0002);
    repeat (2) @(posedge i_clk);
    #1;
    chk("irq_clear", 16'h0000, {15'h0, o_irq});
    rc("mask_rw", `TCC_OFS_MASK, model_q[7]);
    $display("test interrupt done");

    // event counting, match after m+1 events, second match at 3
    m = 3 + ($random(seed) & 3);
    setup(16'h0000, 16'h004b);
    wr(`TCC_OFS_CR0, 16'(m));
    wr(`TCC_OFS_CR1, 16'h0002);
    // compare mode kept for match clear
    wr(`TCC_OFS_TMC, 16'h000c);
    repeat (2) pulse(1'b0);
    rc("ev_two", `TCC_OFS_STAT, 16'h0000);
    pulse(1'b0);
    rc("ev_three", `TCC_OFS_STAT, 16'h0002);
    repeat (m - 3) pulse(1'b0);
    rc("ev_m", `TCC_OFS_STAT, 16'h0002);
    pulse(1'b0);
    rc("ev_m1", `TCC_OFS_STAT, 16'h0003);
    $display("test events done");
    results();
  end
endmodule
